// *** tb/smb_slave_model.sv ***
// Purpose: Behavioural slave device on the far side of the two-wire bus.
// Assumes: Lines are wired-AND with pull-ups and are sampled on the system clock.
// Notes: Acks every address and write byte; after a read NACK it stops sending.
`timescale 1ns/100ps
`default_nettype none
module smb_slave_model (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_stretch,
	input wire logic [7:0] i_rd_byte,
	output logic o_scl_low,
	output logic o_sda_low,
	output logic [3:0] o_bit,
	output logic [7:0] o_addr,
	output logic [7:0] o_rx_byte
);
	logic scl_q, sda_q, act, first, rd, nak;
	logic [7:0] sh, tx;
	logic [5:0] hold;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			{scl_q, sda_q} <= 2'h3;
			{act, first, rd, nak, o_scl_low, o_sda_low} <= 6'h00;
			{sh, tx, o_addr, o_rx_byte} <= 32'h0;
			hold <= 6'h00;
			o_bit <= 4'h0;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			if (hold != 6'h00) hold <= hold - 6'h01;
			else o_scl_low <= 1'b0;
			if (i_scl && scl_q && sda_q && !i_sda) begin
				{act, first, rd, nak, o_sda_low} <= 5'h18;
				o_bit <= 4'hF;
			end else if (i_scl && scl_q && !sda_q && i_sda) begin
				{act, o_sda_low} <= 2'h0;
			end else if (act && !scl_q && i_scl) begin
				if (o_bit < 4'h8) sh <= {sh[6:0], i_sda};
				else nak <= i_sda;
			end else if (act && scl_q && !i_scl) begin
				if (i_stretch) begin
					o_scl_low <= 1'b1;
					hold <= 6'h1E;
				end
				// The fall that closes START only opens the first bit, so it is not counted.
				if (o_bit == 4'hF) begin
					o_bit <= 4'h0;
				end else if (o_bit == 4'h7) begin
					o_bit <= 4'h8;
					o_sda_low <= !rd;
					if (first) begin
						o_addr <= sh;
						rd <= sh[0];
					end else if (!rd) o_rx_byte <= sh;
				end else if (o_bit == 4'h8) begin
					o_bit <= 4'h0;
					first <= 1'b0;
					o_sda_low <= rd && !nak && !i_rd_byte[7];
					tx <= {i_rd_byte[6:0], 1'b0};
				end else begin
					o_bit <= o_bit + 4'h1;
					o_sda_low <= rd && !nak && !tx[7];
					tx <= {tx[6:0], 1'b0};
				end
			end
		end
	end
endmodule : smb_slave_model
`default_nettype wire

// *** tb/smbus_master_slave_controller_bench.sv ***
// Purpose: Self-checking bench for smb_ctrl as master against a slave model.
// Assumes: Only the selected timer source overflows, every 12 clocks.
// Notes: A wrong source choice starves the bit clock, so the waits fail.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module smbus_master_slave_controller_bench;
	typedef struct packed {logic [1:0] sel; logic rd; logic hw; logic ext; logic st; logic [6:0] adr; logic [7:0] dat;} smb_row_t;
	localparam smb_row_t ROWS [5] = '{'{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h52, 8'h5A},
		'{2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h3C, 8'hC3}, '{2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 7'h55, 8'h96},
		'{2'h3, 1'b1, 1'b1, 1'b1, 1'b1, 7'h7F, 8'h01}, '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 7'h00, 8'hFF}};
	logic clk, rst_n, en, slave_inhibit_bit, ext, toe, fte, hw, sreq, preq, ack_o, clr, st, tb_scl_low, tb_sda_low, mon;
	logic scl_oe_n, sda_oe_n, scl_o, sda_o, ackr, si, mst, txm, busy, arb, sflag, pflag, rld;
	logic m_scl_low, m_sda_low, scl_p, oe_p;
	logic [1:0] sel;
	logic [3:0] ovf, m_bit;
	logic [7:0] txd, rdb, rxd, m_addr, m_rx;
	int bad_count, comparisons, tc, run, min_lo, min_hi, fc, min_hold, n;
	wire scl_w = scl_oe_n & !m_scl_low & !tb_scl_low;
	wire sda_w = sda_oe_n & !m_sda_low & !tb_sda_low;
	smb_ctrl u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_scl(scl_w), .i_sda(sda_w),
		.o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_enable(en),
		.i_slave_inhibit(slave_inhibit_bit), .i_ext_hold(ext), .i_scl_to_en(toe), .i_free_to_en(fte), .i_clk_sel(sel),
		.i_tmr_ovf(ovf), .i_hw_ack_en(hw), .i_start_req(sreq), .i_stop_req(preq), .i_tx_data(txd),
		.i_ack_out(ack_o), .i_si_clr(clr), .o_rx_data(rxd), .o_ack_rcvd(ackr), .o_si(si), .o_master(mst),
		.o_tx_mode(txm), .o_busy(busy), .o_arb_lost(arb), .o_start_flag(sflag), .o_stop_flag(pflag),
		.o_tmr_reload(rld));
	smb_slave_model u_slave (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl_w), .i_sda(sda_w), .i_stretch(st),
		.i_rd_byte(rdb), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low), .o_bit(m_bit), .o_addr(m_addr),
		.o_rx_byte(m_rx));
	initial begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	always @(posedge clk) begin
		tc <= (tc == 11) ? 0 : tc + 1;
		ovf <= (tc == 11) ? (4'h1 << sel) : 4'h0;
	end
	// Phase lengths are measured on the SCL wire and hold from its fall to a change of sda_oe_n, a step after the edge to avoid races.
	always @(posedge clk) begin
		#1;
		fc = (scl_p && !scl_w) ? 0 : fc + 1;
		if (sda_oe_n !== oe_p && !scl_w && mon && fc < min_hold) min_hold = fc;
		if (scl_w !== scl_p) begin
			if (mon && mst && scl_p && run < min_hi) min_hi = run;
			if (mon && mst && !scl_p && run < min_lo) min_lo = run;
			run = 1;
		end else run++;
		scl_p = scl_w;
		oe_p = sda_oe_n;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask : step
	task automatic clear;
		clr = 1'b1;
		step(1);
		clr = 1'b0;
	endtask : clear
	task automatic wait_si;
		int k;
		k = 0;
		step(1);
		while (si !== 1'b1 && k < 3000) begin
			step(1);
			k++;
		end
		`CHK(si, 1'b1)
	endtask : wait_si
	task automatic xfer(input smb_row_t r);
		{sel, hw, ext, st, rdb} = {r.sel, r.hw, r.ext, r.st, r.dat};
		sreq = 1'b1;
		wait_si();
		`CHK(sflag, 1'b1)
		step(8);
		`CHK(rld, 1'b0)
		sreq = 1'b0;
		txd = {r.adr, r.rd};
		clear();
		wait_si();
		`CHK(ackr, 1'b1)
		`CHK(m_addr, {r.adr, r.rd})
		`CHK(m_bit, 4'h0)
		txd = r.dat;
		ack_o = 1'b0;
		clear();
		wait_si();
		`CHK(txm, !r.rd)
		if (r.rd) begin
			`CHK(rxd, r.dat)
			`CHK(m_bit, r.hw ? 4'h0 : 4'h8)
		end else begin
			`CHK(ackr, 1'b1)
			`CHK(m_rx, r.dat)
		end
		preq = 1'b1;
		clear();
		for (n = 0; n < 3000 && busy === 1'b1; n++) begin
			if (si === 1'b1) clear();
			else step(1);
		end
		preq = 1'b0;
		`CHK(busy, 1'b0)
		`CHK(scl_w & sda_w, 1'b1)
		`CHK(pflag, 1'b0)
	endtask : xfer
	// Drives one address byte and a STOP by hand; the block answers as a slave only when on is set.
	task automatic slave_pass(input logic on);
		logic [7:0] v;
		v = 8'hA4;
		slave_inhibit_bit = !on;
		ack_o = 1'b1;
		tb_sda_low = 1'b1;
		step(30);
		tb_scl_low = 1'b1;
		step(10);
		for (int b = 7; b >= 0; b--) begin
			tb_sda_low = !v[b];
			step(20);
			tb_scl_low = 1'b0;
			step(30);
			tb_scl_low = 1'b1;
			step(10);
		end
		tb_sda_low = 1'b0;
		step(20);
		`CHK({si, scl_oe_n}, {on, !on})
		clear();
		step(20);
		`CHK(sda_oe_n, !on)
		tb_scl_low = 1'b0;
		step(30);
		tb_scl_low = 1'b1;
		step(10);
		tb_sda_low = 1'b1;
		step(20);
		tb_scl_low = 1'b0;
		step(30);
		tb_sda_low = 1'b0;
		step(20);
		`CHK({si, pflag}, {on, on})
		clear();
	endtask : slave_pass
	task automatic give_verdict;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		{rst_n, en, slave_inhibit_bit, ext, toe, fte, hw, sreq, preq, ack_o, clr, st, tb_scl_low, tb_sda_low, mon} = 15'h3600;
		{sel, txd, rdb, tc, run, fc, bad_count, comparisons} = '0;
		{scl_p, oe_p} = 2'h3;
		step(9);
		`CHK(rld, 1'b0)
		`CHK({scl_oe_n, sda_oe_n, si, busy}, 4'hC)
		`CHK({scl_o, sda_o}, 2'h0)
		step(1);
		rst_n = 1'b1;
		step(10);
		`CHK(rld, 1'b1)
		for (int i = 0; i < 5; i++) begin
			{min_lo, min_hi, min_hold} = {32'd999, 32'd999, 32'd999};
			mon = !ROWS[i].st;
			slave_inhibit_bit = (i == 4); // Master traffic must ignore the slave inhibit.
			xfer(ROWS[i]);
			if (mon) begin
				`CHK(min_lo >= 10, 1'b1)
				`CHK(min_hi >= 13, 1'b1)
				`CHK(min_hold >= (ROWS[i].ext ? 12 : 3), 1'b1)
			end
			step(50);
		end
		{mon, slave_inhibit_bit, sel} = 4'h0;
		// A foreign START with no STOP leaves the bus busy until the free timeout.
		tb_sda_low = 1'b1;
		step(30);
		tb_scl_low = 1'b1;
		step(30);
		tb_sda_low = 1'b0;
		step(30);
		tb_scl_low = 1'b0;
		step(30);
		`CHK(busy, 1'b1)
		sreq = 1'b1;
		step(60);
		`CHK(sda_oe_n, 1'b1)
		xfer(ROWS[0]);
		step(50);
		sreq = 1'b1;
		wait_si();
		sreq = 1'b0;
		txd = 8'hFF;
		clear();
		step(2);
		tb_sda_low = 1'b1;
		for (n = 0; n < 500 && arb !== 1'b1; n++) step(1);
		`CHK(arb, 1'b1)
		step(10);
		`CHK({mst, sda_oe_n}, 2'h1)
		for (n = 0; n < 300 && scl_w !== 1'b1; n++) step(1);
		tb_sda_low = 1'b0;
		step(20);
		`CHK(busy, 1'b0)
		clear();
		step(20);
		slave_pass(1'b1);
		slave_pass(1'b0);
		en = 1'b0;
		sreq = 1'b1;
		step(200);
		`CHK({scl_oe_n, sda_oe_n, mst}, 3'h6)
		{sreq, en, toe} = 3'h2;
		step(10);
		`CHK(rld, 1'b0)
		give_verdict();
	end
endmodule : smbus_master_slave_controller_bench
`default_nettype wire

// *** verilog/smb_cfg.svh ***
// Purpose: Timing counts and field codes for the two-wire bus controller.
// Assumes: System clock of 10 MHz.
// Notes: Counts are in system clocks unless named as ticks of the bit clock.
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH
`define SMB_SYS_CLK_HZ 10000000
`define SMB_RATE_DIV 20
`define SMB_MIN_PHASE_CYC (5'(`SMB_RATE_DIV / 2))
`define SMB_HOLD_CYC 4'h3
`define SMB_HOLD_EXT_CYC 4'hC
`define SMB_SETUP_CYC 4'h1
`define SMB_SETUP_EXT_CYC 4'hB
`define SMB_LOW_TICKS 2'h1
`define SMB_HIGH_TICKS 2'h2
`define SMB_FREE_TICKS 4'hA
`define SMB_ACK_BIT 4'h8
`define SMB_BIT_DONE 4'h9
`define SMB_SEL_T0 2'h0
`define SMB_SEL_T1 2'h1
`define SMB_SEL_T2H 2'h2
`define SMB_SEL_T2L 2'h3
`endif

// *** verilog/smb_ctrl.sv ***
// Purpose: Byte-oriented two-wire bus controller, master and slave, multi-master.
// Assumes: SCL and SDA are open-drain; the enable bits below come from software.
// Notes: Software reacts to o_si and releases the bus with i_si_clr.
`timescale 1ns/100ps
`default_nettype none
`include "smb_cfg.svh"
module smb_ctrl
	import smb_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_o,
	output logic o_scl_oe_n,
	output logic o_sda_o,
	output logic o_sda_oe_n,
	input wire logic i_enable,
	input wire logic i_slave_inhibit,
	input wire logic i_ext_hold,
	input wire logic i_scl_to_en,
	input wire logic i_free_to_en,
	input wire logic [1:0] i_clk_sel,
	input wire logic [3:0] i_tmr_ovf,
	input wire logic i_hw_ack_en,
	input wire logic i_start_req,
	input wire logic i_stop_req,
	input wire logic [7:0] i_tx_data,
	input wire logic i_ack_out,
	input wire logic i_si_clr,
	output logic [7:0] o_rx_data,
	output logic o_ack_rcvd,
	output logic o_si,
	output logic o_master,
	output logic o_tx_mode,
	output logic o_busy,
	output logic o_arb_lost,
	output logic o_start_flag,
	output logic o_stop_flag,
	output logic o_tmr_reload
);
	logic scl_h, sda_h, tick, free_pulse;
	logic scl_d_ff, sda_d_ff;
	logic scl_rise, scl_fall, start_det, stop_det;
	smb_mstate_t m_state_ff;
	logic master_ff, m_scl_low_ff, m_sda_low_ff, arb_lost_ff;
	logic [4:0] m_cyc_ff;
	logic [1:0] m_tick_ff;
	logic [3:0] bit_cnt_ff, hold_ff, setup_ff;
	logic is_addr_ff, rw_ff, addressed_ff, inh_eff_ff;
	logic [7:0] rx_ff, tx_sh_ff;
	logic ack_rcvd_ff, drive_pend_ff, d_sda_low_ff, s_hold_ff;
	logic si_ff, start_flag_ff, stop_flag_ff, busy_ff, reload_ff, tx_mode_ff;
	logic scl_oe_n_ff, sda_oe_n_ff, zero_ff;
	logic txer, slave_on, part, drive_val, setup_ok, ph_ok, low_ok;
	logic arb_lose, start_done, byte_fall, ack_fall, slv_stop, si_set, drive_apply;

	smb_sync u_scl_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_pin(i_scl),
		.o_level(scl_h)
	);
	smb_sync u_sda_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_pin(i_sda),
		.o_level(sda_h)
	);
	smb_tick u_tick (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_ovf(i_tmr_ovf),
		.i_sel(i_clk_sel),
		.i_free_en(i_free_to_en & i_enable),
		.i_bus_high(scl_h & sda_h),
		.o_tick(tick),
		.o_free(free_pulse)
	);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else if (i_ce) begin
			scl_d_ff <= scl_h;
			sda_d_ff <= sda_h;
		end
	end

	assign scl_rise = scl_h & ~scl_d_ff;
	assign scl_fall = ~scl_h & scl_d_ff;
	assign start_det = i_enable & scl_h & scl_d_ff & sda_d_ff & ~sda_h;
	assign stop_det = i_enable & scl_h & scl_d_ff & ~sda_d_ff & sda_h;

	// Address byte is sent by the master; data direction follows the address bit.
	assign txer = master_ff ? (is_addr_ff | ~rw_ff) : (~is_addr_ff & rw_ff & addressed_ff);
	assign slave_on = ~master_ff & ~inh_eff_ff & (is_addr_ff | addressed_ff);
	assign part = master_ff | slave_on;
	assign setup_ok = setup_ff >= (i_ext_hold ? `SMB_SETUP_EXT_CYC : `SMB_SETUP_CYC);
	assign ph_ok = m_cyc_ff >= `SMB_MIN_PHASE_CYC;
	assign low_ok = ph_ok & (m_tick_ff >= `SMB_LOW_TICKS) & ~si_ff & ~drive_pend_ff & setup_ok;
	assign arb_lose = scl_rise & master_ff & txer & (bit_cnt_ff < `SMB_ACK_BIT) & ~d_sda_low_ff
		& ~m_sda_low_ff & ~sda_h;
	assign start_done = (m_state_ff == SMB_M_START) & ph_ok & (m_tick_ff >= `SMB_LOW_TICKS);
	assign byte_fall = scl_fall & (bit_cnt_ff == `SMB_ACK_BIT) & ~txer & ~i_hw_ack_en;
	assign ack_fall = scl_fall & (bit_cnt_ff == `SMB_BIT_DONE) & (txer | i_hw_ack_en);
	assign slv_stop = stop_det & ~master_ff & addressed_ff & ~inh_eff_ff;
	assign si_set = start_done | ((byte_fall | ack_fall) & part) | slv_stop;
	assign drive_apply = drive_pend_ff & (hold_ff == 4'h0) & ~si_ff & ~si_set;

	always_comb begin
		drive_val = 1'b0;
		if (bit_cnt_ff < `SMB_ACK_BIT) begin
			drive_val = txer & ~tx_sh_ff[7];
		end else if (bit_cnt_ff == `SMB_ACK_BIT) begin
			drive_val = ~txer & part & i_ack_out;
		end
	end

	// Master clock generator; it also owns START and STOP shaping.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !i_enable) begin
			m_state_ff <= SMB_M_IDLE;
			master_ff <= 1'b0;
			m_scl_low_ff <= 1'b0;
			m_sda_low_ff <= 1'b0;
			m_cyc_ff <= 5'h00;
			m_tick_ff <= 2'h0;
		end else if (i_ce) begin
			if (m_cyc_ff != 5'h1F) begin
				m_cyc_ff <= m_cyc_ff + 5'h01;
			end
			if (tick && m_tick_ff != 2'h3) begin
				m_tick_ff <= m_tick_ff + 2'h1;
			end
			case (m_state_ff)
				SMB_M_IDLE: begin
					if (i_start_req && (!busy_ff || free_pulse)) begin
						m_state_ff <= SMB_M_START;
						m_sda_low_ff <= 1'b1;
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end
				end
				SMB_M_START: begin
					if (start_done) begin
						m_state_ff <= SMB_M_LOW;
						master_ff <= 1'b1;
						m_scl_low_ff <= 1'b1;
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end
				end
				SMB_M_LOW: begin
					if (drive_apply) begin
						m_sda_low_ff <= 1'b0;
					end
					if (low_ok) begin
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
						if (i_stop_req && bit_cnt_ff == 4'h0 && !is_addr_ff) begin
							m_state_ff <= SMB_M_STOP1;
							m_sda_low_ff <= 1'b1;
						end else begin
							m_state_ff <= SMB_M_HIGH;
							m_scl_low_ff <= 1'b0;
						end
					end
				end
				SMB_M_HIGH: begin
					if (arb_lose) begin
						m_state_ff <= SMB_M_IDLE;
						master_ff <= 1'b0;
					end else if (!scl_h && scl_d_ff) begin
						// Another master pulled SCL low first: follow it.
						m_state_ff <= SMB_M_LOW;
						m_scl_low_ff <= 1'b1;
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end else if (!scl_h) begin
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end else if (ph_ok && m_tick_ff >= `SMB_HIGH_TICKS) begin
						m_state_ff <= SMB_M_LOW;
						m_scl_low_ff <= 1'b1;
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end
				end
				SMB_M_STOP1: begin
					if (ph_ok) begin
						m_state_ff <= SMB_M_STOP2;
						m_scl_low_ff <= 1'b0;
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end
				end
				SMB_M_STOP2: begin
					if (!scl_h) begin
						m_cyc_ff <= 5'h00;
						m_tick_ff <= 2'h0;
					end else if (ph_ok && m_tick_ff >= `SMB_LOW_TICKS) begin
						m_state_ff <= SMB_M_IDLE;
						m_sda_low_ff <= 1'b0;
						master_ff <= 1'b0;
					end
				end
				default: begin
					m_state_ff <= SMB_M_IDLE;
				end
			endcase
		end
	end

	// Bit engine, common to both roles, paced by the bus clock edges.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !i_enable) begin
			bit_cnt_ff <= 4'h0;
			is_addr_ff <= 1'b0;
			rw_ff <= 1'b0;
			addressed_ff <= 1'b0;
			inh_eff_ff <= 1'b0;
			rx_ff <= 8'h00;
			tx_sh_ff <= 8'hFF;
			ack_rcvd_ff <= 1'b0;
			hold_ff <= 4'h0;
			drive_pend_ff <= 1'b0;
			d_sda_low_ff <= 1'b0;
			setup_ff <= 4'h0;
		end else if (i_ce) begin
			if (setup_ff != 4'hF) begin
				setup_ff <= setup_ff + 4'h1;
			end
			if (start_det) begin
				bit_cnt_ff <= 4'h0;
				is_addr_ff <= 1'b1;
				addressed_ff <= 1'b0;
				inh_eff_ff <= i_slave_inhibit;
				drive_pend_ff <= 1'b0;
				d_sda_low_ff <= 1'b0;
			end else begin
				if (scl_rise) begin
					if (bit_cnt_ff < `SMB_ACK_BIT) begin
						rx_ff <= {rx_ff[6:0], sda_h};
						tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
						if (is_addr_ff && bit_cnt_ff == 4'h7) begin
							rw_ff <= sda_h;
						end
					end else begin
						ack_rcvd_ff <= ~sda_h;
						if (is_addr_ff && !master_ff && d_sda_low_ff) begin
							addressed_ff <= 1'b1;
						end
					end
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end
				if (scl_fall) begin
					hold_ff <= i_ext_hold ? `SMB_HOLD_EXT_CYC : `SMB_HOLD_CYC;
					drive_pend_ff <= 1'b1;
					if (bit_cnt_ff == `SMB_BIT_DONE) begin
						bit_cnt_ff <= 4'h0;
						is_addr_ff <= 1'b0;
					end
				end else if (drive_pend_ff) begin
					if (hold_ff != 4'h0) begin
						hold_ff <= hold_ff - 4'h1;
					end
					if (drive_apply) begin
						d_sda_low_ff <= drive_val;
						drive_pend_ff <= 1'b0;
						setup_ff <= 4'h0;
					end
				end
			end
			if (arb_lose || m_state_ff == SMB_M_STOP1 || m_state_ff == SMB_M_STOP2) begin
				d_sda_low_ff <= 1'b0;
			end
			if (si_ff && i_si_clr) begin
				tx_sh_ff <= i_tx_data;
			end
		end
	end

	// Interrupt, status flags and the slave clock stretch. A set beats a clear.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !i_enable) begin
			si_ff <= 1'b0;
			start_flag_ff <= 1'b0;
			stop_flag_ff <= 1'b0;
			arb_lost_ff <= 1'b0;
			s_hold_ff <= 1'b0;
			busy_ff <= 1'b0;
			reload_ff <= 1'b0;
			tx_mode_ff <= 1'b0;
		end else if (i_ce) begin
			if (si_set) begin
				si_ff <= 1'b1;
			end else if (i_si_clr) begin
				si_ff <= 1'b0;
			end
			if (start_done) begin
				start_flag_ff <= 1'b1;
			end else if (i_si_clr) begin
				start_flag_ff <= 1'b0;
			end
			if (slv_stop) begin
				stop_flag_ff <= 1'b1;
			end else if (i_si_clr) begin
				stop_flag_ff <= 1'b0;
			end
			if (arb_lose) begin
				arb_lost_ff <= 1'b1;
			end else if (i_si_clr) begin
				arb_lost_ff <= 1'b0;
			end
			// A slave only ever holds SCL low while its byte interrupt is open.
			if (si_set && scl_fall && !master_ff) begin
				s_hold_ff <= 1'b1;
			end else if (i_si_clr) begin
				s_hold_ff <= 1'b0;
			end
			if (start_det || m_state_ff == SMB_M_START) begin
				busy_ff <= 1'b1;
			end else if (stop_det || free_pulse) begin
				busy_ff <= 1'b0;
			end
			reload_ff <= i_scl_to_en & scl_h;
			tx_mode_ff <= txer;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !i_enable) begin
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
			zero_ff <= 1'b0;
		end else if (i_ce) begin
			scl_oe_n_ff <= ~(m_scl_low_ff | s_hold_ff);
			sda_oe_n_ff <= ~(m_sda_low_ff | d_sda_low_ff);
			zero_ff <= 1'b0;
		end
	end

	assign o_scl_o = zero_ff;
	assign o_sda_o = zero_ff;
	assign o_scl_oe_n = scl_oe_n_ff;
	assign o_sda_oe_n = sda_oe_n_ff;
	assign o_rx_data = rx_ff;
	assign o_ack_rcvd = ack_rcvd_ff;
	assign o_si = si_ff;
	assign o_master = master_ff;
	assign o_tx_mode = tx_mode_ff;
	assign o_busy = busy_ff;
	assign o_arb_lost = arb_lost_ff;
	assign o_start_flag = start_flag_ff;
	assign o_stop_flag = stop_flag_ff;
	assign o_tmr_reload = reload_ff;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n || !i_enable || !i_ce);

	property p_start_free;
		(m_state_ff == SMB_M_IDLE && i_start_req && busy_ff && !free_pulse) |=> m_state_ff == SMB_M_IDLE;
	endproperty
	a_start_free: assert property (p_start_free) else $error("Start issued on busy bus.");
	property p_free_start;
		(m_state_ff == SMB_M_IDLE && i_start_req && free_pulse) |=> m_sda_low_ff ##1 !sda_oe_n_ff;
	endproperty
	a_free_start: assert property (p_free_start) else $error("No START after free timeout.");
	property p_arb;
		arb_lose |=> (!master_ff && !d_sda_low_ff) ##1 sda_oe_n_ff;
	endproperty
	a_arb: assert property (p_arb) else $error("SDA still driven after lost arbitration.");
	property p_stretch;
		(m_state_ff == SMB_M_HIGH && !scl_h && !scl_d_ff) |=> !m_scl_low_ff && m_tick_ff == 2'h0;
	endproperty
	a_stretch: assert property (p_stretch) else $error("High phase counted while SCL low.");
	property p_reload;
		(i_scl_to_en && scl_h) |=> o_tmr_reload;
	endproperty
	a_reload: assert property (p_reload) else $error("Timeout timer not reloaded while SCL high.");
	property p_hold;
		(scl_fall && !i_ext_hold) |=> $stable(d_sda_low_ff) [*3];
	endproperty
	a_hold: assert property (p_hold) else $error("SDA changed inside hold time.");
	property p_inh_nack;
		(is_addr_ff && inh_eff_ff && !master_ff) |-> !d_sda_low_ff;
	endproperty
	a_inh_nack: assert property (p_inh_nack) else $error("Inhibited slave drove address ACK.");
	property p_si_ack;
		(ack_fall && part) |=> si_ff;
	endproperty
	a_si_ack: assert property (p_si_ack) else $error("No interrupt after ACK bit.");
	property p_si_rx;
		(byte_fall && part) |=> si_ff && !d_sda_low_ff;
	endproperty
	a_si_rx: assert property (p_si_rx) else $error("No interrupt before software ACK.");
	property p_min_phase;
		($fell(m_scl_low_ff) && master_ff) |-> $past(m_cyc_ff) >= `SMB_MIN_PHASE_CYC;
	endproperty
	a_min_phase: assert property (p_min_phase) else $error("SCL low phase too short.");
	property p_busy_clr;
		stop_det |=> !busy_ff;
	endproperty
	a_busy_clr: assert property (p_busy_clr) else $error("Busy still set after STOP.");
endmodule : smb_ctrl
`default_nettype wire

// *** verilog/smb_pkg.sv ***
// Purpose: Types shared by the two-wire bus controller.
// Assumes: Nothing.
// Notes: Timing counts live in smb_cfg.svh.
package smb_pkg;
	typedef enum logic [2:0] {
		SMB_M_IDLE = 3'b000,
		SMB_M_START = 3'b001,
		SMB_M_LOW = 3'b010,
		SMB_M_HIGH = 3'b011,
		SMB_M_STOP1 = 3'b100,
		SMB_M_STOP2 = 3'b101
	} smb_mstate_t;
endpackage : smb_pkg

// *** verilog/smb_sync.sv ***
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Idle bus level is high.
// Notes: The level changes only when the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module smb_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_pin,
	output logic o_level
);
	logic s1_ff, s2_ff, s3_ff, level_ff;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			level_ff <= 1'b1;
		end else if (i_ce) begin
			s1_ff <= i_pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end
	assign o_level = level_ff;
endmodule : smb_sync
`default_nettype wire

// *** verilog/smb_tick.sv ***
// Purpose: Bit clock source select and bus-free timeout.
// Assumes: Timer overflow pulses are one system clock wide, same clock.
// Notes: The free pulse fires on the eleventh tick of an all-high bus.
`timescale 1ns/100ps
`default_nettype none
`include "smb_cfg.svh"
module smb_tick (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [3:0] i_ovf,
	input wire logic [1:0] i_sel,
	input wire logic i_free_en,
	input wire logic i_bus_high,
	output logic o_tick,
	output logic o_free
);
	logic tick_ff, free_ff;
	logic [3:0] cnt_ff;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tick_ff <= 1'b0;
		end else if (i_ce) begin
			tick_ff <= i_ovf[i_sel];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt_ff <= 4'h0;
			free_ff <= 1'b0;
		end else if (i_ce) begin
			free_ff <= 1'b0;
			if (!i_free_en || !i_bus_high) begin
				cnt_ff <= 4'h0;
			end else if (tick_ff && cnt_ff <= `SMB_FREE_TICKS) begin
				cnt_ff <= cnt_ff + 4'h1;
				free_ff <= (cnt_ff == `SMB_FREE_TICKS);
			end
		end
	end
	assign o_tick = tick_ff;
	assign o_free = free_ff;
endmodule : smb_tick
`default_nettype wire
